/* File: rtl/mwo_params.svh */
// Constants for the monitor, watchdog and OTP configuration bank.
// Assumes nothing; included by the package and the bank module.
`ifndef MWO_PARAMS_SVH
`define MWO_PARAMS_SVH

`define MWO_MCLK_MHZ 10
`define MWO_AW 8
`define MWO_DW 16

`define MWO_ADDR_GAIN 8'h29
`define MWO_ADDR_MON1 8'h2B
`define MWO_ADDR_MON2 8'h2C
`define MWO_ADDR_MON3 8'h2D
`define MWO_ADDR_WDOG 8'h2E
`define MWO_ADDR_SCRATCH 8'h36
`define MWO_ADDR_OTP 8'h48

`define MWO_RST_GAIN 16'h0000
`define MWO_RST_MON1 16'h4002
`define MWO_RST_MON2 16'h1101
`define MWO_RST_MON3 16'h003B
`define MWO_RST_WDOG 16'h0000
`define MWO_RST_SCRATCH 16'h0000

`define MWO_MASK_GAIN 16'h8FFF
`define MWO_MASK_MON1 16'hFFFF
`define MWO_MASK_MON2 16'hFFFF
`define MWO_MASK_MON3 16'h01FB
`define MWO_MASK_WDOG 16'h003F

`define MWO_OTP_VER_BIT 4
`define MWO_OTP_ACC_HI 3
`define MWO_OTP_ACC_LO 1
`define MWO_OTP_PRG_BIT 0
`define MWO_OTP_KEY1 3'h2
`define MWO_OTP_KEY2 3'h1
`define MWO_OTP_KEY3 3'h4
`define MWO_OTP_OPEN 3'h7

`define MWO_WD_UNIT_US 500
`define MWO_WD_FAULTS 2'h3
`define MWO_SHUNT_DEG_TENTHS_US0 20
`define MWO_SHUNT_DEG_TENTHS_US1 40
`define MWO_SHUNT_DEG_TENTHS_US2 60
`define MWO_SHUNT_DEG_TENTHS_US3 100

`endif

/* File: rtl/mwo_pkg.sv */
// Types shared by the monitor, watchdog and OTP configuration bank.
// Assumes the constant header is on the include path.
`include "mwo_params.svh"

package mwo_pkg;
   typedef enum logic [1:0] {
      mwo_unlock_idle,
      mwo_unlock_one,
      mwo_unlock_two,
      mwo_unlock_open
   } mwo_unlock_t;

   typedef struct packed {
      logic [15:0] gain;
      logic [15:0] mon1;
      logic [15:0] mon2;
      logic [15:0] mon3;
      logic [15:0] wdog;
      logic [15:0] scratch;
      mwo_unlock_t unlock;
      logic otp_prg;
      logic otp_ver;
      logic otp_crc_fail;
      logic bootstrap_undervolt_flag_flag;
      logic wd_fault_flag;
      logic [19:0] wd_count;
      logic [1:0] wd_faults;
      logic [15:0] rdata;
      logic [1:0] bst_sync;
   } mwo_state_t;
endpackage

/* File: rtl/mwo_config.sv */
// Monitor, watchdog and user OTP configuration bank with its register port.
// Assumes a serial front end that turns frames into one-cycle read and write
// strobes on mclk, and an OTP engine that pulses done on mclk.
//
// Function
// - Divider select: clear half, set eighth
// - Gain codes decode; eight and above give forty
// - Gain fields writable at any time
// - Drain overvoltage level decode, reset 01b
// - Supply mode bits: warning or fault
// - Bootstrap undervoltage flag live or latched
// - Latched bootstrap mode picks warning or fault
// - Bootstrap level bit picks 4.2V/7.2V
// - Two-bit modes: warn, fault, reserved, silent
// - Blanking and deglitch selects with reset values
// - Gate level bit picks 5.7V/7.7V
// - Shunt level codes 50 to 500mV
// - Shunt deglitch codes 2 to 10us
// - Watchdog fault: pin low, optional shutdown
// - Optional three-fault count before report
// - Service by mapped read or scratch write, per mode bit
// - Window select sets lower and upper times
// - Scratch register; its write is a service in write mode
// - Unlock sequence 2,1,4 reads back seven
// - Program bit cleared when programming ends
// - Verify runs CRC, flags failure
`timescale 1ns/100ps

`include "mwo_params.svh"

module mwo_config
   import mwo_pkg::*;
#(
   parameter int WD_UNIT_CYC = `MWO_WD_UNIT_US * `MWO_MCLK_MHZ
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic reg_hit,
   output logic [15:0] reg_rdata,
   input wire logic bootstrap_undervolt_flag_detect,
   input wire logic fault_clear,
   input wire logic otp_prog_done,
   input wire logic otp_verify_done,
   input wire logic otp_crc_ok,
   output logic ref_divider_select,
   output logic [5:0] amp_gain_phase1,
   output logic [5:0] amp_gain_phase2,
   output logic [5:0] amp_gain_phase3,
   output logic [9:0] drain_ov_threshold_dv,
   output logic [7:0] supply_fault_mode,
   output logic [6:0] bootstrap_uv_threshold_dv,
   output logic bootstrap_undervolt_flag,
   output logic bootstrap_uv_fault,
   output logic power_undervolt_warn_level,
   output logic [1:0] power_overvolt_level,
   output logic [2:0] monitor_report,
   output logic [2:0] monitor_shutdown,
   output logic [2:0] drain_source_oc_blanking,
   output logic [2:0] drain_source_oc_deglitch,
   output logic [2:0] gate_source_blanking,
   output logic [2:0] gate_source_deglitch,
   output logic [6:0] gate_source_threshold_dv,
   output logic [9:0] shunt_oc_threshold_mv,
   output logic [7:0] shunt_oc_deglitch_cycles,
   output logic watchdog_fault_flag,
   output logic fault_indicator_pin_n,
   output logic watchdog_gate_shutdown,
   output logic otp_program_start,
   output logic otp_verify_start,
   output logic otp_crc_fail_flag
);

   localparam logic [19:0] WD_UNIT = 20'(WD_UNIT_CYC);
   localparam logic [7:0] DEG_DIV = 8'(10 / `MWO_MCLK_MHZ);

   mwo_state_t st;
   mwo_state_t next_st;

   // Gain code to gain value; undefined codes saturate at forty
   function automatic logic [5:0] gain_of(input logic [3:0] code);
      case (code)
         4'h0: gain_of = 6'd5;
         4'h1: gain_of = 6'd10;
         4'h2: gain_of = 6'd12;
         4'h3: gain_of = 6'd16;
         4'h4: gain_of = 6'd20;
         4'h5: gain_of = 6'd23;
         4'h6: gain_of = 6'd25;
         4'h7: gain_of = 6'd30;
         default: gain_of = 6'd40;
      endcase
   endfunction

   // Two-bit monitor mode: {report, shutdown}; reserved code reports only
   function automatic logic [1:0] mode_of(input logic [1:0] code);
      case (code)
         2'h0: mode_of = 2'b10;
         2'h1: mode_of = 2'b11;
         2'h3: mode_of = 2'b00;
         default: mode_of = 2'b10;
      endcase
   endfunction

   function automatic logic is_addr(input logic [7:0] a);
      is_addr = (a == `MWO_ADDR_GAIN) || (a == `MWO_ADDR_MON1) ||
         (a == `MWO_ADDR_MON2) || (a == `MWO_ADDR_MON3) ||
         (a == `MWO_ADDR_WDOG) || (a == `MWO_ADDR_SCRATCH) ||
         (a == `MWO_ADDR_OTP);
   endfunction

   logic wr_gain;
   logic wr_mon1;
   logic wr_mon2;
   logic wr_mon3;
   logic wr_wdog;
   logic wr_scratch;
   logic wr_otp;
   logic service;
   logic wd_on;
   logic [19:0] wd_low;
   logic [19:0] wd_high;
   logic wd_event;
   logic [2:0] acc;
   logic bst_live;
   logic [1:0] m_ds;
   logic [1:0] m_gs;
   logic [1:0] m_sh;

   assign reg_hit = is_addr(reg_addr);
   assign wr_gain = reg_wr && (reg_addr == `MWO_ADDR_GAIN);
   assign wr_mon1 = reg_wr && (reg_addr == `MWO_ADDR_MON1);
   assign wr_mon2 = reg_wr && (reg_addr == `MWO_ADDR_MON2);
   assign wr_mon3 = reg_wr && (reg_addr == `MWO_ADDR_MON3);
   assign wr_wdog = reg_wr && (reg_addr == `MWO_ADDR_WDOG);
   assign wr_scratch = reg_wr && (reg_addr == `MWO_ADDR_SCRATCH);
   assign wr_otp = reg_wr && (reg_addr == `MWO_ADDR_OTP);
   assign acc = reg_wdata[`MWO_OTP_ACC_HI:`MWO_OTP_ACC_LO];
   assign bst_live = st.bst_sync[1];

   // Service source follows the mode bit; a read to an unmapped address is no service
   assign service = st.wdog[3] ? wr_scratch : (reg_rd && reg_hit);
   assign wd_on = st.wdog[0];

   // Window lengths scale from one half-millisecond unit
   always_comb begin
      case (st.wdog[2:1])
         2'h0: begin
            wd_low = WD_UNIT;
            wd_high = 20'(WD_UNIT * 20);
         end
         2'h1: begin
            wd_low = 20'(WD_UNIT * 2);
            wd_high = 20'(WD_UNIT * 40);
         end
         default: begin
            wd_low = 20'(WD_UNIT * 4);
            wd_high = 20'(WD_UNIT * 80);
         end
      endcase
   end

   // A service inside the lower window or a silent upper window is a fault
   assign wd_event = wd_on && ((service && (st.wd_count < wd_low)) ||
      (!service && (st.wd_count >= wd_high - 20'd1)));

   always_comb begin
      next_st = st;
      next_st.bst_sync = {st.bst_sync[0], bootstrap_undervolt_flag_detect};
      next_st.rdata = st.rdata;

      // Gain fields take writes regardless of drive activity
      if (wr_gain) begin
         next_st.gain = reg_wdata & `MWO_MASK_GAIN;
      end
      if (wr_mon1) begin
         next_st.mon1 = reg_wdata & `MWO_MASK_MON1;
      end
      if (wr_mon2) begin
         next_st.mon2 = reg_wdata & `MWO_MASK_MON2;
      end
      if (wr_mon3) begin
         next_st.mon3 = reg_wdata & `MWO_MASK_MON3;
      end
      if (wr_wdog) begin
         next_st.wdog = reg_wdata & `MWO_MASK_WDOG;
      end
      if (wr_scratch) begin
         next_st.scratch = reg_wdata;
      end

      // Unlock sequence; a wrong key that equals the first key restarts at step one
      if (wr_otp) begin
         case (st.unlock)
            mwo_unlock_idle: begin
               next_st.unlock = (acc == `MWO_OTP_KEY1) ? mwo_unlock_one : mwo_unlock_idle;
            end
            mwo_unlock_one: begin
               if (acc == `MWO_OTP_KEY2) begin
                  next_st.unlock = mwo_unlock_two;
               end else begin
                  next_st.unlock = (acc == `MWO_OTP_KEY1) ? mwo_unlock_one : mwo_unlock_idle;
               end
            end
            mwo_unlock_two: begin
               if (acc == `MWO_OTP_KEY3) begin
                  next_st.unlock = mwo_unlock_open;
               end else begin
                  next_st.unlock = (acc == `MWO_OTP_KEY1) ? mwo_unlock_one : mwo_unlock_idle;
               end
            end
            default: begin
               next_st.unlock = mwo_unlock_idle;
            end
         endcase
      end

      // Program only when open; verify wins if both are asked for at once
      if (wr_otp && reg_wdata[`MWO_OTP_VER_BIT] && !st.otp_prg) begin
         next_st.otp_ver = 1'b1;
         next_st.otp_crc_fail = 1'b0;
      end else if (st.otp_ver && otp_verify_done) begin
         next_st.otp_ver = 1'b0;
         next_st.otp_crc_fail = !otp_crc_ok;
      end
      if (wr_otp && reg_wdata[`MWO_OTP_PRG_BIT] && !reg_wdata[`MWO_OTP_VER_BIT] &&
         st.unlock == mwo_unlock_open && !st.otp_ver) begin
         next_st.otp_prg = 1'b1;
      end else if (st.otp_prg && otp_prog_done) begin
         next_st.otp_prg = 1'b0;
      end

      // Bootstrap flag: live copy, or sticky until cleared with the condition gone
      if (!st.mon1[11]) begin
         next_st.bootstrap_undervolt_flag_flag = bst_live;
      end else if (bst_live) begin
         next_st.bootstrap_undervolt_flag_flag = 1'b1;
      end else if (fault_clear) begin
         next_st.bootstrap_undervolt_flag_flag = 1'b0;
      end

      // Watchdog timer and consecutive-fault counter
      if (!wd_on) begin
         next_st.wd_count = '0;
         next_st.wd_faults = '0;
      end else if (service || wd_event) begin
         next_st.wd_count = '0;
      end else begin
         next_st.wd_count = st.wd_count + 20'd1;
      end
      if (wd_event) begin
         if (!st.wdog[4]) begin
            next_st.wd_fault_flag = 1'b1;
         end else if (st.wd_faults == `MWO_WD_FAULTS - 2'd1) begin
            next_st.wd_fault_flag = 1'b1;
            next_st.wd_faults = '0;
         end else begin
            next_st.wd_faults = st.wd_faults + 2'd1;
         end
      end else if (wd_on && service) begin
         next_st.wd_faults = '0;
      end
      // A fault in the clearing cycle survives the clear
      if (fault_clear && !wd_event) begin
         next_st.wd_fault_flag = 1'b0;
      end

      // Read data is captured on the strobe; unmapped reads return zero
      if (reg_rd) begin
         case (reg_addr)
            `MWO_ADDR_GAIN: next_st.rdata = st.gain;
            `MWO_ADDR_MON1: next_st.rdata = st.mon1;
            `MWO_ADDR_MON2: next_st.rdata = st.mon2;
            `MWO_ADDR_MON3: next_st.rdata = st.mon3;
            `MWO_ADDR_WDOG: next_st.rdata = st.wdog;
            `MWO_ADDR_SCRATCH: next_st.rdata = st.scratch;
            `MWO_ADDR_OTP: begin
               next_st.rdata = '0;
               next_st.rdata[`MWO_OTP_VER_BIT] = st.otp_ver;
               next_st.rdata[`MWO_OTP_ACC_HI:`MWO_OTP_ACC_LO] =
                  (st.unlock == mwo_unlock_open) ? `MWO_OTP_OPEN : 3'h0;
            end
            default: next_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.gain <= `MWO_RST_GAIN;
         st.mon1 <= `MWO_RST_MON1;
         st.mon2 <= `MWO_RST_MON2;
         st.mon3 <= `MWO_RST_MON3;
         st.wdog <= `MWO_RST_WDOG;
         st.scratch <= `MWO_RST_SCRATCH;
         st.unlock <= mwo_unlock_idle;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;

   assign ref_divider_select = st.gain[15];
   assign amp_gain_phase1 = gain_of(st.gain[11:8]);
   assign amp_gain_phase2 = gain_of(st.gain[7:4]);
   assign amp_gain_phase3 = gain_of(st.gain[3:0]);

   // Thresholds are reported in tenths of a volt
   always_comb begin
      case (st.mon1[15:14])
         2'h0: drain_ov_threshold_dv = 10'd295;
         2'h1: drain_ov_threshold_dv = 10'd345;
         default: drain_ov_threshold_dv = 10'd535;
      endcase
   end

   // Bit order: drain, bst ov, digital ov, gate ov, gate uv, pump ov, pump uv, power ov
   assign supply_fault_mode = {st.mon1[13], st.mon1[12], st.mon1[8], st.mon1[7],
      st.mon1[6], st.mon1[5], st.mon1[4], st.mon1[0]};
   assign bootstrap_uv_threshold_dv = st.mon1[9] ? 7'd72 : 7'd42;
   assign bootstrap_undervolt_flag = st.bootstrap_undervolt_flag_flag;
   // Mode bit only counts once the flag is latching
   assign bootstrap_uv_fault = st.mon1[11] && st.mon1[10] && st.bootstrap_undervolt_flag_flag;
   assign power_undervolt_warn_level = st.mon1[3];
   assign power_overvolt_level = st.mon1[2:1];

   // Index 0 drain-source, 1 gate-source, 2 shunt
   assign m_ds = mode_of(st.mon2[15:14]);
   assign m_gs = mode_of(st.mon2[7:6]);
   assign m_sh = mode_of(st.mon3[7:6]);
   assign monitor_report = {m_sh[1], m_gs[1], m_ds[1]};
   assign monitor_shutdown = {m_sh[0], m_gs[0], m_ds[0]};
   assign drain_source_oc_blanking = st.mon2[13:11];
   assign drain_source_oc_deglitch = st.mon2[10:8];
   assign gate_source_blanking = st.mon2[5:3];
   assign gate_source_deglitch = st.mon2[2:0];
   assign gate_source_threshold_dv = st.mon3[8] ? 7'd77 : 7'd57;

   always_comb begin
      case (st.mon3[5:3])
         3'h0: shunt_oc_threshold_mv = 10'd50;
         3'h1: shunt_oc_threshold_mv = 10'd75;
         3'h2: shunt_oc_threshold_mv = 10'd100;
         3'h3: shunt_oc_threshold_mv = 10'd125;
         3'h4: shunt_oc_threshold_mv = 10'd150;
         3'h5: shunt_oc_threshold_mv = 10'd200;
         3'h6: shunt_oc_threshold_mv = 10'd300;
         default: shunt_oc_threshold_mv = 10'd500;
      endcase
   end

   // Deglitch held in tenths of a microsecond, turned into mclk cycles
   always_comb begin
      case (st.mon3[1:0])
         2'h0: shunt_oc_deglitch_cycles = 8'(`MWO_SHUNT_DEG_TENTHS_US0) / DEG_DIV;
         2'h1: shunt_oc_deglitch_cycles = 8'(`MWO_SHUNT_DEG_TENTHS_US1) / DEG_DIV;
         2'h2: shunt_oc_deglitch_cycles = 8'(`MWO_SHUNT_DEG_TENTHS_US2) / DEG_DIV;
         default: shunt_oc_deglitch_cycles = 8'(`MWO_SHUNT_DEG_TENTHS_US3) / DEG_DIV;
      endcase
   end

   assign watchdog_fault_flag = st.wd_fault_flag;
   // Pin always reports; shutdown only in fault mode
   assign fault_indicator_pin_n = !st.wd_fault_flag;
   assign watchdog_gate_shutdown = st.wd_fault_flag && st.wdog[5];
   assign otp_program_start = st.otp_prg;
   assign otp_verify_start = st.otp_ver;
   assign otp_crc_fail_flag = st.otp_crc_fail;

endmodule // mwo_config

/* File: sim/mwo_host_model.sv */
// Host side of the register port: one-cycle read and write strobes.
// Assumes the bank samples strobes on the rising mclk edge.
`timescale 1ns/100ps
module mwo_host_model (
   input wire logic mclk,
   input wire logic [15:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // Callers never set program and verify in one write
   // Callers wait for program and verify to clear before reuse
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
      // Stale data is not held, so a late sample shows up
      reg_wdata = ~d;
   endtask
   // Mapped reads double as watchdog service while the mode bit selects read service
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule // mwo_host_model

/* File: sim/mwo_monitor.sv */
// Port checker for the configuration bank.
// Assumes it is bound to mwo_config, single mclk domain.
`timescale 1ns/100ps
`include "mwo_params.svh"
module mwo_monitor (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_hit,
   input wire logic [15:0] reg_rdata,
   input wire logic fault_clear,
   input wire logic otp_prog_done,
   input wire logic otp_verify_done,
   input wire logic otp_crc_ok,
   input wire logic ref_divider_select,
   input wire logic [5:0] amp_gain_phase3,
   input wire logic [9:0] drain_ov_threshold_dv,
   input wire logic [7:0] shunt_oc_deglitch_cycles,
   input wire logic watchdog_fault_flag,
   input wire logic fault_indicator_pin_n,
   input wire logic watchdog_gate_shutdown,
   input wire logic otp_program_start,
   input wire logic otp_verify_start,
   input wire logic otp_crc_fail_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic gw;
   assign gw = reg_wr && reg_addr == `MWO_ADDR_GAIN;
   a_unmapped_read_zero: assert property (reg_rd && !reg_hit |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_fault_pin_tracks: assert property (fault_indicator_pin_n != watchdog_fault_flag)
      else $error("fault pin does not track flag");
   a_shutdown_needs_flag: assert property (watchdog_gate_shutdown |-> watchdog_fault_flag)
      else $error("shutdown without fault");
   a_divider_write: assert property (gw |=> ref_divider_select == $past(reg_wdata[15]))
      else $error("divider select not updated");
   a_gain_top_code: assert property (gw && reg_wdata[3:0] > 4'h8 |=> amp_gain_phase3 == 6'd40)
      else $error("high gain code not forty");
   a_drain_top_level: assert property (reg_wr && reg_addr == `MWO_ADDR_MON1 && reg_wdata[15]
      |=> drain_ov_threshold_dv == 10'd535) else $error("drain level wrong");
   a_shunt_deg_top: assert property (reg_wr && reg_addr == `MWO_ADDR_MON3 && reg_wdata[1:0] == 2'h3
      |=> shunt_oc_deglitch_cycles == 8'd100) else $error("shunt deglitch wrong");
   a_flag_sticky: assert property (watchdog_fault_flag && !fault_clear |=> watchdog_fault_flag)
      else $error("watchdog flag dropped");
   a_prg_clears: assert property (otp_program_start && otp_prog_done |=> !otp_program_start)
      else $error("program bit not cleared");
   a_verify_result: assert property (otp_verify_start && otp_verify_done
      |=> !otp_verify_start && otp_crc_fail_flag == !$past(otp_crc_ok)) else $error("verify wrong");
endmodule // mwo_monitor
bind mwo_config mwo_monitor mwo_monitor_i (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_hit, .reg_rdata, .fault_clear, .otp_prog_done, .otp_verify_done, .otp_crc_ok,
   .ref_divider_select, .amp_gain_phase3, .drain_ov_threshold_dv, .shunt_oc_deglitch_cycles,
   .watchdog_fault_flag, .fault_indicator_pin_n, .watchdog_gate_shutdown, .otp_program_start,
   .otp_verify_start, .otp_crc_fail_flag);

/* File: sim/tb_top.sv */
// Self-checking bench for the configuration bank.
// Assumes 10 MHz mclk; watchdog unit shortened to 10 cycles.
`timescale 1ns/100ps
module tb_top;
   logic mclk, rstn, bootstrap_undervolt_flag_detect, fault_clear, otp_prog_done, otp_verify_done, otp_crc_ok;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic reg_wr, reg_rd, reg_hit, ref_div, bst_flag, bst_fault, wd_flag, pin_n, wd_sd;
   logic prg, ver, crc_fail, puwl;
   logic [5:0] g1, g2, g3;
   logic [9:0] drain_dv, shunt_mv;
   logic [7:0] sfm, shunt_deg;
   logic [6:0] bst_dv, gs_dv;
   logic [1:0] povl;
   logic [2:0] rep, sd, dsb, dsd, gsb, gsd;
   int bad_count, tests_run, cyc;
   mwo_host_model mwo_host_model_i (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   mwo_config #(.WD_UNIT_CYC(10)) mwo_config_i (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_hit(reg_hit),
      .reg_rdata(reg_rdata), .bootstrap_undervolt_flag_detect(bootstrap_undervolt_flag_detect), .fault_clear(fault_clear),
      .otp_prog_done(otp_prog_done), .otp_verify_done(otp_verify_done), .otp_crc_ok(otp_crc_ok),
      .ref_divider_select(ref_div), .amp_gain_phase1(g1), .amp_gain_phase2(g2),
      .amp_gain_phase3(g3), .drain_ov_threshold_dv(drain_dv), .supply_fault_mode(sfm),
      .bootstrap_uv_threshold_dv(bst_dv), .bootstrap_undervolt_flag(bst_flag),
      .bootstrap_uv_fault(bst_fault), .power_undervolt_warn_level(puwl),
      .power_overvolt_level(povl), .monitor_report(rep), .monitor_shutdown(sd),
      .drain_source_oc_blanking(dsb), .drain_source_oc_deglitch(dsd),
      .gate_source_blanking(gsb), .gate_source_deglitch(gsd), .gate_source_threshold_dv(gs_dv),
      .shunt_oc_threshold_mv(shunt_mv), .shunt_oc_deglitch_cycles(shunt_deg),
      .watchdog_fault_flag(wd_flag), .fault_indicator_pin_n(pin_n),
      .watchdog_gate_shutdown(wd_sd), .otp_program_start(prg), .otp_verify_start(ver),
      .otp_crc_fail_flag(crc_fail));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic wrap_up();
      if (bad_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Ceiling well above the roughly 2000 cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic w(input logic [7:0] a, input logic [15:0] d);
      mwo_host_model_i.wr(a, d);
   endtask
   task automatic r(input logic [7:0] a);
      mwo_host_model_i.rd(a, rv);
   endtask
   task automatic clr();
      fault_clear = 1'b1;
      idle(1);
      fault_clear = 1'b0;
      idle(1);
   endtask
   task automatic do_reset();
      rstn = 1'b0;
      idle(6);
      rstn = 1'b1;
   endtask
   task automatic t_regs();
      logic [7:0] ad [7] = '{8'h29, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h36, 8'h48};
      logic [15:0] rs [7] = '{16'h0, 16'h4002, 16'h1101, 16'h003B, 16'h0, 16'h0, 16'h0};
      logic [15:0] mk [6] = '{16'h8FFF, 16'hFFFF, 16'hFFFF, 16'h01FB, 16'h003F, 16'hFFFF};
      for (int i = 0; i < 7; i++) begin
         r(ad[i]);
         chk(rv, rs[i]);
         chk({15'h0, reg_hit}, 16'h1);
      end
      r(8'h30);
      chk({reg_hit, rv[14:0]}, 16'h0);
      chk({4'h0, dsb, dsd, gsb, gsd}, 16'h0441);
      chk({13'h0, puwl, povl}, 16'h0001);
      chk({drain_dv, shunt_deg[5:0]}, {10'd345, 6'd36});
      for (int i = 0; i < 6; i++) begin
         w(ad[i], 16'hFFFF);
         r(ad[i]);
         chk(rv, mk[i]);
      end
      do_reset();
   endtask
   task automatic t_gain();
      int gv [16] = '{5, 10, 12, 16, 20, 23, 25, 30, 40, 40, 40, 40, 40, 40, 40, 40};
      for (int c = 0; c < 16; c++) begin
         w(8'h29, {c[0], 3'b000, c[3:0], ~c[3:0], c[3:0] ^ 4'h5});
         chk({10'h0, g1}, 16'(gv[c]));
         chk({10'h0, g2}, 16'(gv[15 - c]));
         chk({10'h0, g3}, 16'(gv[c ^ 5]));
         chk({15'h0, ref_div}, 16'(c % 2));
      end
   endtask
   task automatic t_mon();
      int dv [4] = '{295, 345, 535, 535};
      int mv [8] = '{50, 75, 100, 125, 150, 200, 300, 500};
      int dg [4] = '{20, 40, 60, 100};
      for (int i = 0; i < 4; i++) begin
         w(8'h2B, {i[1:0], 14'h0002});
         chk({6'h0, drain_dv}, 16'(dv[i]));
         w(8'h2C, {i[1:0], 6'h00, i[1:0], 6'h00});
         w(8'h2D, {8'h00, i[1:0], 6'h00});
         chk({10'h0, rep, sd}, {10'h0, {3{i != 3}}, {3{i == 1}}});
      end
      for (int i = 0; i < 8; i++) begin
         w(8'h2D, {7'h00, i[0], 2'b00, i[2:0], 1'b0, i[1:0]});
         chk({6'h0, shunt_mv}, 16'(mv[i]));
         chk({8'h0, shunt_deg}, 16'(dg[i % 4]));
         chk({9'h0, gs_dv}, i[0] ? 16'd77 : 16'd57);
      end
      w(8'h2B, 16'h31F1);
      chk({8'h0, sfm}, 16'h00FF);
      w(8'h2B, 16'h2200);
      chk({sfm, 1'b0, bst_dv}, 16'h8048);
      w(8'h2B, 16'h000C);
      chk({13'h0, puwl, povl}, 16'h0006);
   endtask
   task automatic t_bst();
      for (int k = 0; k < 2; k++) begin
         bootstrap_undervolt_flag_detect = 1'b1;
         idle(4);
         chk({15'h0, bst_flag}, 16'h1);
         bootstrap_undervolt_flag_detect = 1'b0;
         idle(4);
         chk({14'h0, bst_flag, bst_fault}, k ? 16'h3 : 16'h0);
         w(8'h2B, 16'h0C00);
      end
      clr();
      chk({15'h0, bst_flag}, 16'h0);
   endtask
   task automatic t_wd();
      w(8'h2E, 16'h0021);
      r(8'h36);
      idle(2);
      chk({13'h0, wd_flag, pin_n, wd_sd}, 16'h5);
      clr();
      // Service by write only: a read must not restart the timer
      w(8'h2E, 16'h0009);
      idle(100);
      r(8'h2E);
      idle(150);
      chk({13'h0, wd_flag, pin_n, wd_sd}, 16'h4);
      clr();
      idle(50);
      w(8'h36, 16'h1234);
      idle(180);
      chk({15'h0, wd_flag}, 16'h0);
      idle(40);
      chk({15'h0, wd_flag}, 16'h1);
      w(8'h2E, 16'h0000);
      clr();
      w(8'h2E, 16'h0011);
      for (int k = 0; k < 3; k++) begin
         r(8'h36);
         idle(2);
         chk({15'h0, wd_flag}, 16'(k / 2));
      end
      w(8'h2E, 16'h0000);
      clr();
      // Window 01b, then window 11b with the longest upper limit
      for (int k = 0; k < 2; k++) begin
         w(8'h2E, k ? 16'h000F : 16'h000B);
         idle(k ? 780 : 380);
         chk({15'h0, wd_flag}, 16'h0);
         idle(40);
         chk({15'h0, wd_flag}, 16'h1);
         w(8'h2E, 16'h0000);
         clr();
      end
   endtask
   task automatic t_otp();
      w(8'h48, 16'h0004);
      w(8'h48, 16'h0002);
      r(8'h48);
      chk(rv, 16'h0000);
      w(8'h48, 16'h0008);
      r(8'h48);
      chk(rv, 16'h000E);
      // Watchdog must be off before programming starts
      r(8'h2E);
      chk(rv, 16'h0000);
      w(8'h48, 16'h0001);
      r(8'h48);
      chk({prg, rv[14:0]}, 16'h8000);
      otp_prog_done = 1'b1;
      idle(1);
      otp_prog_done = 1'b0;
      idle(1);
      chk({15'h0, prg}, 16'h0);
      w(8'h48, 16'h0004);
      w(8'h48, 16'h0006);
      w(8'h48, 16'h0008);
      w(8'h48, 16'h0001);
      chk({15'h0, prg}, 16'h0);
      for (int k = 0; k < 2; k++) begin
         otp_crc_ok = k[0];
         w(8'h48, 16'h0010);
         chk({15'h0, ver}, 16'h1);
         otp_verify_done = 1'b1;
         idle(1);
         otp_verify_done = 1'b0;
         idle(1);
         chk({14'h0, ver, crc_fail}, {14'h0, 1'b0, ~k[0]});
      end
   endtask
   initial begin
      rstn = 1'b0;
      bootstrap_undervolt_flag_detect = 1'b0;
      fault_clear = 1'b0;
      otp_prog_done = 1'b0;
      otp_verify_done = 1'b0;
      otp_crc_ok = 1'b1;
      do_reset();
      t_regs();
      t_gain();
      t_mon();
      t_bst();
      t_wd();
      t_otp();
      wrap_up();
   end
endmodule // tb_top
